/* src/ucsh_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
`default_nettype none
module ucsh_fifo
   import ucsh_pkg::*;
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   // Clock and control
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic             clkEn,
   input  wire logic             flush,
   // Fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr_r;
   logic [AW:0]      rdPtr_r;
   logic [AW:0]      wrPtr_nxt;
   logic [AW:0]      rdPtr_nxt;
   logic             inReady_r;
   logic             push;
   logic             pop;

   assign inReady  = inReady_r;
   assign outValid = wrPtr_r != rdPtr_r;
   assign outData  = mem[rdPtr_r[AW-1:0]];
   assign push     = inValid && inReady_r;
   assign pop      = outValid && outReady;

   // Next pointers are worked out ahead so that the not-full flag can be a register.
   always_comb begin
      wrPtr_nxt = wrPtr_r;
      rdPtr_nxt = rdPtr_r;
      if (flush) begin
         wrPtr_nxt = '0;
         rdPtr_nxt = '0;
      end else begin
         if (push) begin
            wrPtr_nxt = wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_nxt = rdPtr_r + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clkEn && push) begin
         mem[wrPtr_r[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wrPtr_r   <= '0;
         rdPtr_r   <= '0;
         inReady_r <= 1'b1;
      end else if (clkEn) begin
         wrPtr_r   <= wrPtr_nxt;
         rdPtr_r   <= rdPtr_nxt;
         inReady_r <= (wrPtr_nxt - rdPtr_nxt) != (AW+1)'(DEPTH);
      end
   end
endmodule
`default_nettype wire

/* src/ucsh_pkg.sv */
// Package with constants and carrier types for the control-endpoint setup handler.
`default_nettype none
package ucsh_pkg;
   localparam int          DATA_W        = 8;
   localparam int          FIFO_DEPTH    = 32;
   localparam int          PID_W         = 4;
   localparam int          CLK_MHZ       = 200;
   localparam int          SUSPEND_US    = 3000;
   localparam int          SUSPEND_CYC   = SUSPEND_US * CLK_MHZ;
   localparam int          CNT_W         = 20;
   localparam logic [3:0]  PID_SETUP     = 4'hd;
   localparam logic [3:0]  PID_IN        = 4'h9;
   localparam logic [3:0]  PID_OUT       = 4'h1;
   localparam logic [3:0]  PID_DATA1     = 4'hb;
   localparam logic [3:0]  PID_ACK       = 4'h2;
   localparam logic [3:0]  PID_NAK       = 4'ha;
   localparam logic [3:0]  PID_STALL     = 4'he;
   localparam logic        FLAG_RST      = 1'b0;
   localparam logic [1:0]  EP_EN_RST     = 2'b00;

   // Token seen on the bus: its PID and whether the request data stage is IN.
   typedef struct packed {
      logic [PID_W-1:0] pid;
      logic             dirIn;
   } ucsh_token_t;

   // Handshake or data packet sent back to the host.
   typedef struct packed {
      logic [PID_W-1:0]  pid;
      logic              last;
      logic [DATA_W-1:0] data;
   } ucsh_reply_t;
endpackage
`default_nettype wire

/* src/ucsh_setup_ctrl.sv */
// Endpoint-0 setup handling: flag, NAK hold-off, gating, module reset, suspend.
`default_nettype none
// Overview of operation
// - A SETUP token for an IN control transfer sets the setup flag while the module enable is set.
// - Setting the setup flag raises the interrupt request toward the processor.
// - While the setup flag is set, every IN token that finds the reply slot free is answered with NAK, or with STALL if both endpoint-0 enables are clear.
// - The processor clears the setup flag by a write strobe after decoding.
// - With both endpoint-0 enables clear, a clear of the setup flag is gated off.
// - Setting both endpoint-0 enables again resumes normal endpoint operation.
// - Clearing the module enable resets all function state, including transmit.
// - Bus idle for the suspend time is detected and reported to software while the PLL enable (pllEnable) is set.
module ucsh_setup_ctrl
   import ucsh_pkg::*;
#(
   parameter int SUSPEND_CYCLES = SUSPEND_CYC
) (
   // Clock, reset and enable
   input  wire logic              ref_clk,
   input  wire logic              reset,
   input  wire logic              clkEn,
   // Processor controls
   input  wire logic              moduleEnable,
   input  wire logic              inEp0Enable,
   input  wire logic              outEp0Enable,
   input  wire logic              setupFlagClear,
   input  wire logic              pllEnable,
   // Processor IN data
   input  wire logic              txValid,
   output logic                   txReady,
   input  wire logic [DATA_W-1:0] txData,
   input  wire logic              txLast,
   // Bus token side
   input  wire logic              tokenValid,
   input  wire ucsh_token_t       token,
   input  wire logic              busActivity,
   // Bus reply side
   output logic                   replyValid,
   input  wire logic              replyReady,
   output ucsh_reply_t            reply,
   // Status
   output logic                   setupReceivedFlag,
   output logic                   usbIrq,
   output logic                   suspendFlag,
   output logic                   epEnabledStatus
);
   // Transaction phase: idle, NAK hold-off after a SETUP, and the data stage.
   typedef enum logic [1:0] {ST_IDLE, ST_NAK, ST_DATA} ucsh_state_t;

   ucsh_state_t          state_r;
   logic                 setupFlag_r;
   logic                 irq_r;
   logic                 suspend_r;
   logic                 epEn_r;
   logic [CNT_W-1:0]     idleCnt_r;
   logic                 replyValid_r;
   ucsh_reply_t          reply_r;
   logic                 fifoOutValid;
   logic                 fifoOutReady;
   logic [DATA_W:0]      fifoOutData;
   logic                 funcRst;
   logic                 epEnabled;
   logic                 setupEvt;
   logic                 clearEff;
   logic                 inTok;
   logic                 replyFree;

   // Control terms shared by the processes below.
   assign funcRst   = !moduleEnable;
   assign epEnabled = inEp0Enable || outEp0Enable;
   assign setupEvt  = tokenValid && token.pid == PID_SETUP && token.dirIn;
   assign clearEff  = setupFlagClear && epEnabled;
   assign inTok     = tokenValid && token.pid == PID_IN;
   assign replyFree = !replyValid_r || replyReady;

   // Prepared IN words wait here until the host asks for them.
   ucsh_fifo #(
      .WIDTH (DATA_W + 1),
      .DEPTH (FIFO_DEPTH)
   ) txFifo (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .clkEn    (clkEn),
      .flush    (funcRst),
      .inValid  (txValid && moduleEnable),
      .inReady  (txReady),
      .inData   ({txLast, txData}),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutData)
   );

   // Words leave the queue only while the data stage owns the reply slot.
   assign fifoOutReady = clkEn && moduleEnable && state_r == ST_DATA && replyFree && !setupEvt;

   // Setup flag: a new SETUP wins over a simultaneous clear.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         setupFlag_r <= FLAG_RST;
      end else if (clkEn) begin
         if (funcRst) begin
            setupFlag_r <= FLAG_RST;
         end else if (setupEvt) begin
            setupFlag_r <= 1'b1;
         end else if (clearEff) begin
            setupFlag_r <= 1'b0;
         end
      end
   end

   // Interrupt request follows the setup flag.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irq_r <= 1'b0;
      end else if (clkEn) begin
         irq_r <= !funcRst && (setupFlag_r || setupEvt);
      end
   end

   // Endpoint enable status, restored once both enables are set.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         epEn_r <= 1'b0;
      end else if (clkEn) begin
         epEn_r <= moduleEnable && inEp0Enable && outEp0Enable;
      end
   end

   // Transaction state machine.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_r <= ST_IDLE;
      end else if (clkEn) begin
         if (funcRst) begin
            state_r <= ST_IDLE;
         end else begin
            unique case (state_r)
               ST_IDLE: begin
                  if (setupEvt) begin
                     state_r <= ST_NAK;
                  end
               end
               ST_NAK: begin
                  if (inTok && !setupFlag_r && epEn_r && fifoOutValid && replyFree) begin
                     state_r <= ST_DATA;
                  end
               end
               ST_DATA: begin
                  if (setupEvt) begin
                     state_r <= ST_NAK;
                  end else if (fifoOutValid && fifoOutReady && fifoOutData[DATA_W]) begin
                     state_r <= ST_IDLE;
                  end
               end
               default: begin
                  state_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Reply register toward the bus.
   // A new SETUP takes the reply slot ahead of a queued data word.
   // An IN token in idle, or with no data ready, is answered with NAK, or with STALL if both endpoint-0 enables are clear.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         replyValid_r <= 1'b0;
         reply_r      <= '0;
      end else if (clkEn) begin
         if (funcRst) begin
            replyValid_r <= 1'b0;
            reply_r      <= '0;
         end else if (replyFree) begin
            replyValid_r <= 1'b0;
            if (state_r == ST_DATA && fifoOutValid && !setupEvt) begin
               replyValid_r <= 1'b1;
               reply_r      <= '{pid: PID_DATA1, last: fifoOutData[DATA_W],
                                 data: fifoOutData[DATA_W-1:0]};
            end else if (inTok) begin
               replyValid_r <= 1'b1;
               if (!epEnabled) begin
                  reply_r <= '{pid: PID_STALL, last: 1'b1, data: '0};
               end else if (setupFlag_r || setupEvt || !epEn_r || !fifoOutValid ||
                            state_r != ST_NAK) begin
                  reply_r <= '{pid: PID_NAK, last: 1'b1, data: '0};
               end else begin
                  replyValid_r <= 1'b0;
               end
            end else if (setupEvt) begin
               replyValid_r <= 1'b1;
               reply_r      <= '{pid: PID_ACK, last: 1'b1, data: '0};
            end
         end
      end
   end

   // Suspend detection by counting idle bus cycles.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         idleCnt_r <= '0;
         suspend_r <= 1'b0;
      end else if (clkEn) begin
         if (funcRst || busActivity || tokenValid) begin
            idleCnt_r <= '0;
            suspend_r <= 1'b0;
         end else if (idleCnt_r >= CNT_W'(SUSPEND_CYCLES - 1)) begin
            suspend_r <= pllEnable;
         end else begin
            idleCnt_r <= idleCnt_r + 1'b1;
         end
      end
   end

   assign setupReceivedFlag = setupFlag_r;
   assign usbIrq            = irq_r;
   assign suspendFlag       = suspend_r;
   assign epEnabledStatus   = epEn_r;
   assign replyValid        = replyValid_r;
   assign reply             = reply_r;
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the setup handler against the host model.
`default_nettype none
module testbench
   import ucsh_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SUSP = 50;
   logic ref_clk, reset, moduleEnable, inEp0Enable, outEp0Enable, setupFlagClear, pllEnable;
   logic txValid, txReady, txLast, tokenValid, busActivity, replyValid, replyReady, slow;
   logic setupReceivedFlag, usbIrq, suspendFlag, epEnabledStatus;
   logic [DATA_W-1:0] txData;
   ucsh_token_t       token;
   ucsh_reply_t       reply;
   int                mismatches = 0;
   int                checked = 0;
   ucsh_setup_ctrl #(.SUSPEND_CYCLES(SUSP)) ucsh_setup_ctrl_inst (.ref_clk(ref_clk),
      .reset(reset), .clkEn(1'b1), .moduleEnable(moduleEnable), .inEp0Enable(inEp0Enable),
      .outEp0Enable(outEp0Enable), .setupFlagClear(setupFlagClear), .pllEnable(pllEnable),
      .txValid(txValid), .txReady(txReady), .txData(txData), .txLast(txLast),
      .tokenValid(tokenValid), .token(token), .busActivity(busActivity),
      .replyValid(replyValid), .replyReady(replyReady), .reply(reply),
      .setupReceivedFlag(setupReceivedFlag), .usbIrq(usbIrq), .suspendFlag(suspendFlag),
      .epEnabledStatus(epEnabledStatus));
   ucsh_host_model ucsh_host_model_inst (.ref_clk(ref_clk), .slow(slow),
      .tokenValid(tokenValid), .token(token), .busActivity(busActivity),
      .replyValid(replyValid), .replyReady(replyReady), .reply(reply));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (mismatches == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic pulseClear();
      setupFlagClear <= 1'b1;
      tick(1);
      setupFlagClear <= 1'b0;
      tick(2);
   endtask
   // Handshakes are judged by their code alone, data packets in full.
   task automatic expectReply(input logic [3:0] pid, input logic last, input logic [7:0] d);
      ucsh_reply_t r;
      int          n;
      r = 'x;
      n = 0;
      while (ucsh_host_model_inst.rxQ.size() == 0 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      if (ucsh_host_model_inst.rxQ.size() > 0) begin
         r = ucsh_host_model_inst.rxQ.pop_front();
      end
      if (pid == PID_DATA1) begin
         check({3'h0, r}, {3'h0, pid, last, d});
      end else begin
         check(16'(r.pid), 16'(pid));
      end
      @(posedge ref_clk);
   endtask
   task automatic fill(input int n);
      for (int i = 0; i < n; i++) begin
         txValid <= 1'b1;
         txData <= 8'(i);
         txLast <= (i == n - 1);
         do @(posedge ref_clk); while (!txReady);
      end
      txValid <= 1'b0;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (3000) @(posedge ref_clk);
      mismatches++;
      results();
   end
   initial begin
      reset = 1'b1;
      moduleEnable = 1'b1;
      inEp0Enable = 1'b1;
      outEp0Enable = 1'b1;
      {setupFlagClear, pllEnable, txValid, txLast, slow} = 5'h00;
      txData = 8'h00;
      tick(3);
      reset <= 1'b0;
      tick(1);
      check(16'({setupReceivedFlag, usbIrq, suspendFlag}), 16'h0000);
      ucsh_host_model_inst.sendToken(PID_SETUP, 1'b1);
      expectReply(PID_ACK, 1'b0, 8'h00);
      check(16'({setupReceivedFlag, usbIrq}), 16'h0003);
      fill(FIFO_DEPTH);
      tick(1);
      check(16'(txReady), 16'h0000);
      ucsh_host_model_inst.sendToken(PID_IN, 1'b1);
      expectReply(PID_NAK, 1'b0, 8'h00);
      inEp0Enable <= 1'b0;
      outEp0Enable <= 1'b0;
      tick(1);
      pulseClear();
      check(16'(setupReceivedFlag), 16'h0001);
      check(16'(epEnabledStatus), 16'h0000);
      ucsh_host_model_inst.sendToken(PID_IN, 1'b1);
      expectReply(PID_STALL, 1'b0, 8'h00);
      inEp0Enable <= 1'b1;
      outEp0Enable <= 1'b1;
      tick(3);
      check(16'(epEnabledStatus), 16'h0001);
      pulseClear();
      check(16'({setupReceivedFlag, usbIrq}), 16'h0000);
      slow <= 1'b1;
      ucsh_host_model_inst.sendToken(PID_IN, 1'b1);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         expectReply(PID_DATA1, i == FIFO_DEPTH - 1, 8'(i));
      end
      tick(2);
      check(16'(txReady), 16'h0001);
      slow <= 1'b0;
      pllEnable <= 1'b1;
      tick(SUSP + 10);
      check(16'(suspendFlag), 16'h0001);
      ucsh_host_model_inst.sendToken(PID_SETUP, 1'b1);
      expectReply(PID_ACK, 1'b0, 8'h00);
      check(16'(suspendFlag), 16'h0000);
      tick(SUSP - 10);
      check(16'(suspendFlag), 16'h0000);
      tick(10);
      check(16'(suspendFlag), 16'h0001);
      moduleEnable <= 1'b0;
      tick(3);
      check(16'({setupReceivedFlag, suspendFlag, replyValid}), 16'h0000);
      moduleEnable <= 1'b1;
      pllEnable <= 1'b0;
      tick(2);
      ucsh_host_model_inst.sendToken(PID_SETUP, 1'b1);
      expectReply(PID_ACK, 1'b0, 8'h00);
      results();
   end
endmodule
bind ucsh_setup_ctrl ucsh_monitor #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) ucsh_monitor_inst (
   .ref_clk, .reset, .clkEn, .moduleEnable, .pllEnable, .inEp0Enable, .outEp0Enable,
   .setupFlagClear, .tokenValid, .busActivity, .replyValid, .token, .reply,
   .setupReceivedFlag, .usbIrq, .suspendFlag, .epEnabledStatus);
`default_nettype wire

/* verification/ucsh_host_model.sv */
// Behavioural host controller that sends tokens and takes replies.
`default_nettype none
module ucsh_host_model
   import ucsh_pkg::*;
(
   // Clock and pacing
   input  wire logic        ref_clk,
   input  wire logic        slow,
   // Token side
   output logic             tokenValid,
   output ucsh_token_t      token,
   output logic             busActivity,
   // Reply side
   input  wire logic        replyValid,
   output logic             replyReady,
   input  wire ucsh_reply_t reply
);
   timeunit 1ns;
   timeprecision 1ps;
   ucsh_reply_t rxQ[$];
   initial begin
      tokenValid = 1'b0;
      token = '0;
      busActivity = 1'b0;
      replyReady = 1'b0;
   end
   // Replies are taken at the edge where valid and ready meet; slow mode stalls.
   always @(posedge ref_clk) begin
      replyReady <= slow ? !replyReady : 1'b1;
      if (replyValid && replyReady) begin
         rxQ.push_back(reply);
      end
   end
   task automatic sendToken(input logic [PID_W-1:0] pid, input logic dirIn);
      tokenValid <= 1'b1;
      token <= '{pid, dirIn};
      busActivity <= 1'b1;
      @(posedge ref_clk);
      tokenValid <= 1'b0;
      token <= ~token;
      busActivity <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* verification/ucsh_monitor.sv */
// Checker that watches the ports of the setup handler.
`default_nettype none
module ucsh_monitor
   import ucsh_pkg::*;
#(
   parameter int SUSPEND_CYCLES = SUSPEND_CYC
) (
   // Clock, reset and enables
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        clkEn,
   input  wire logic        moduleEnable,
   input  wire logic        pllEnable,
   // Processor controls
   input  wire logic        inEp0Enable,
   input  wire logic        outEp0Enable,
   input  wire logic        setupFlagClear,
   // Bus side
   input  wire logic        tokenValid,
   input  wire logic        busActivity,
   input  wire logic        replyValid,
   input  wire ucsh_token_t token,
   input  wire ucsh_reply_t reply,
   // Status
   input  wire logic        setupReceivedFlag,
   input  wire logic        usbIrq,
   input  wire logic        suspendFlag,
   input  wire logic        epEnabledStatus
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic [CNT_W-1:0] idleCnt_r;
   wire logic        bothEn = inEp0Enable && outEp0Enable;
   wire logic        run    = clkEn && moduleEnable;
   sequence tokSeq(p);
      tokenValid && run && token.pid == p;
   endsequence
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         idleCnt_r <= '0;
      end else if (busActivity || !moduleEnable || !pllEnable) begin
         idleCnt_r <= '0;
      end else if (clkEn && idleCnt_r != '1) begin
         idleCnt_r <= idleCnt_r + 1'b1;
      end
   end
   chk_setup_sets: assert property (
      tokSeq(PID_SETUP) ##0 token.dirIn |=> setupReceivedFlag) else $error("flag not set");
   chk_irq_on_set: assert property (
      $rose(setupReceivedFlag) |-> usbIrq) else $error("irq missing");
   chk_irq_drop: assert property (
      !setupReceivedFlag [*2] |-> !usbIrq) else $error("irq without flag");
   chk_nak_hold: assert property (
      tokSeq(PID_IN) ##0 (setupReceivedFlag && bothEn && epEnabledStatus && !replyValid
      && !setupFlagClear) |=> replyValid && reply.pid == PID_NAK) else $error("no NAK");
   chk_flag_clear: assert property (
      run && setupFlagClear && (inEp0Enable || outEp0Enable) && !tokenValid
      |=> !setupReceivedFlag) else $error("clear ignored");
   chk_clear_gated: assert property (
      run && setupFlagClear && !inEp0Enable && !outEp0Enable && setupReceivedFlag
      |=> setupReceivedFlag) else $error("gated clear took effect");
   chk_ep_resume: assert property (
      run && bothEn |=> epEnabledStatus) else $error("endpoint not resumed");
   chk_module_reset: assert property (
      clkEn && !moduleEnable |=> !setupReceivedFlag && !replyValid && !suspendFlag)
      else $error("module reset incomplete");
   chk_suspend_seen: assert property (
      idleCnt_r > CNT_W'(SUSPEND_CYCLES + 2) |-> suspendFlag) else $error("no suspend");
   chk_suspend_clear: assert property (
      clkEn && busActivity |=> !suspendFlag) else $error("suspend kept over activity");
endmodule
`default_nettype wire
